// >>> spi_status_cfg.svh
// Offsets, field positions, reset values and sizes of the status block.
`ifndef SPI_STATUS_CFG_SVH
`define SPI_STATUS_CFG_SVH
`define OFS_EVENT_STATUS 16'h0008
`define OFS_BUFFER_STATUS 16'h000B
`define OFS_INT_MASK 16'h000C
`define OFS_PROTOCOL_CONFIG 16'h0004
`define BIT_TS_CAPTURE_B 9
`define BIT_TS_CAPTURE_A 8
`define BIT_PHY_IRQ 7
`define BIT_RESET_DONE 6
`define BIT_HDR_ERR 5
`define BIT_FRAMING_LOSS 4
`define BIT_RX_OVF 3
`define BIT_TX_UNF 2
`define BIT_TX_OVF 1
`define BIT_TX_PROTO 0
`define BIT_TX_CUT_THROUGH 9
`define RST_EVENT_STATUS 8'h40
`define RST_INT_MASK 8'hBF
`define RST_TX_CREDIT 8'h3C
`define RST_RX_READY 8'h00
`define RST_PAYLOAD_SIZE 3'h6
`define PAYLOAD_8 3'h3
`define PAYLOAD_16 3'h4
`define PAYLOAD_32 3'h5
`define PAYLOAD_64 3'h6
`define BUFFER_BYTES 4096
`define CREDIT_COUNT_W 8
`define TS_BITS_ZERO 2'h0
`endif

// >>> spi_status_pkg.sv
// Types shared by the status block.
`default_nettype none
package spi_status_pkg;
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_OPEN = 2'b01
  } frame_state_t;
endpackage
`default_nettype wire

// >>> mask_store.sv
// Small register store for the interrupt mask, read data from a flop.
`default_nettype none
`include "spi_status_cfg.svh"
module mask_store (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Write port.
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  // Read data.
  output logic [7:0] maskQ
);
  // Mask bit 5 is read-only at one; all others follow writes.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      maskQ <= `RST_INT_MASK;
    else if (wrEn)
      maskQ <= wrData | 8'h20;
  end
endmodule
`default_nettype wire

// >>> spi_macphy_status_buffer_flags.sv
// Status flags, buffer credits and footer fields of the SPI MAC+PHY.
//
// Contract
// - PHY interrupt flag bit 7, read-only.
// - Reset-done flag bit 6, resets to one.
// - Reset-done drives interrupt output, unmaskable.
// - Reset-done sets footer extended-status bit.
// - Write one clears reset-done flag.
// - Header parity error sets sticky bit 5.
// - Early chip-select release sets bit 4.
// - Dropped receive frame sets bit 3.
// - Transmit underflow sets bit 2.
// - Underflow only possible in cut-through mode.
// - Transmit overflow sets bit 1.
// - Data without start sets protocol error.
// - Repeated start before end flags error.
// - End without start flags protocol error.
// - Offsets beyond payload size flag error.
// - Timestamp bits 9 and 8 read zero.
// - Transmit credits in bits 15:8, reset 0x3C.
// - Low five credit bits go in footer.
// - Receive chunks ready in bits 7:0.
// - Low five ready bits go in footer.
// - Four kilobyte transmit and receive buffers.
// - Mask bits gate interrupt and footer flag.
// - Payload size codes 3 to 6, default 6.
`default_nettype none
`include "spi_status_cfg.svh"
module spi_macphy_status_buffer_flags (
  // Device clock and reset.
  input wire logic clk,
  input wire logic rst,
  // SPI-side clock domain, running while chip select is active.
  input wire logic spiClk,
  input wire logic spiRst,
  // Chip select, active low, from the pin.
  input wire logic chipSelN,
  // Chunk header from the SPI link, one pulse per parsed header.
  input wire logic hdrValid,
  input wire logic hdrParityOk,
  input wire logic hdrIsData,
  input wire logic dataValid,
  input wire logic startValid,
  input wire logic [3:0] startWordOfs,
  input wire logic endValid,
  input wire logic [5:0] endByteOfs,
  // Transaction still in progress on the link.
  input wire logic xferActive,
  // Events from the datapath on clk; phyIrq is a level, the others one-cycle pulses.
  input wire logic phyIrq,
  input wire logic resetProcDone,
  input wire logic rxFrameDropped,
  input wire logic txUnderflow,
  input wire logic txOverflow,
  input wire logic txChunkTaken,
  input wire logic txChunkFreed,
  input wire logic rxChunkReady,
  input wire logic rxChunkRead,
  // Register access port.
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  // Footer and interrupt.
  output logic extendedStatusIndication,
  output logic [4:0] footerTxCredit,
  output logic [4:0] footerRxReady,
  output logic interruptOutN,
  output logic [2:0] chunkPayloadSize
);
  // Buffer depth in chunks of the default payload size.
  localparam int TxChunks = `BUFFER_BYTES / 64;

  logic [7:0] status_r;
  logic [7:0] txCredit_r;
  logic [7:0] rxReady_r;
  logic [2:0] payloadSize_r;
  logic txCutThrough_r;
  logic [7:0] maskQ;
  logic [7:0] setEv;
  logic [7:0] clrEv;
  logic protoErrSync;
  logic hdrErrSync;
  logic framingSync;
  logic wrStatus;
  logic wrMask;
  logic wrConfig;

  // Address decode used in several places.
  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction

  assign wrStatus = regWr && hit(regAddr, `OFS_EVENT_STATUS);
  assign wrMask = regWr && hit(regAddr, `OFS_INT_MASK);
  assign wrConfig = regWr && hit(regAddr, `OFS_PROTOCOL_CONFIG);

  // ---- Link domain: chunk protocol checking on spiClk.
  spi_status_pkg::frame_state_t frame_r;
  logic protoTog_r;
  logic hdrTog_r;
  logic [2:0] sizeSync1_r;
  logic [2:0] sizeSync2_r;
  logic [2:0] sizeSync3_r;
  logic [2:0] sizeUse_r;
  logic [5:0] payloadBytes;
  logic badOfs;
  logic protoErr;

  // Payload size crosses as a quasi-static level; a code is taken only
  // when two synchronised samples agree, so a torn capture is never used.
  always_ff @(posedge spiClk or posedge spiRst)
  begin
    if (spiRst)
    begin
      sizeSync1_r <= `RST_PAYLOAD_SIZE;
      sizeSync2_r <= `RST_PAYLOAD_SIZE;
      sizeSync3_r <= `RST_PAYLOAD_SIZE;
      sizeUse_r <= `RST_PAYLOAD_SIZE;
    end
    else
    begin
      sizeSync1_r <= payloadSize_r;
      sizeSync2_r <= sizeSync1_r;
      sizeSync3_r <= sizeSync2_r;
      if (sizeSync2_r == sizeSync3_r)
        sizeUse_r <= sizeSync2_r;
    end
  end

  // Payload size in bytes minus one, per size code.
  always_comb
  begin
    case (sizeUse_r)
      `PAYLOAD_8: payloadBytes = 6'h07;
      `PAYLOAD_16: payloadBytes = 6'h0F;
      `PAYLOAD_32: payloadBytes = 6'h1F;
      default: payloadBytes = 6'h3F;
    endcase
  end

  // Start offset counts words of four bytes.
  assign badOfs = ({startWordOfs, 2'b00} > payloadBytes) ||
                  (endValid && endByteOfs > payloadBytes);

  // Protocol errors of a data header against the open-frame state.
  always_comb
  begin
    protoErr = 1'b0;
    if (hdrValid && hdrParityOk && hdrIsData && dataValid)
    begin
      if (badOfs)
        protoErr = 1'b1;
      else if (frame_r == spi_status_pkg::FR_IDLE && !startValid)
        protoErr = 1'b1;
      else if (frame_r == spi_status_pkg::FR_OPEN && startValid &&
               !endValid)
        protoErr = 1'b1;
    end
  end

  // Frame tracking; an end closes the frame, a start opens one.
  always_ff @(posedge spiClk or posedge spiRst)
  begin
    if (spiRst)
      frame_r <= spi_status_pkg::FR_IDLE;
    else if (hdrValid && hdrParityOk && hdrIsData && dataValid && !protoErr)
    begin
      if (startValid)
        frame_r <= endValid ? spi_status_pkg::FR_IDLE :
                   spi_status_pkg::FR_OPEN;
      else if (endValid)
        frame_r <= spi_status_pkg::FR_IDLE;
    end
    else if (protoErr)
      frame_r <= spi_status_pkg::FR_IDLE;
  end

  // Events leave the link domain as toggles.
  always_ff @(posedge spiClk or posedge spiRst)
  begin
    if (spiRst)
    begin
      protoTog_r <= 1'b0;
      hdrTog_r <= 1'b0;
    end
    else
    begin
      if (protoErr)
        protoTog_r <= ~protoTog_r;
      if (hdrValid && !hdrParityOk)
        hdrTog_r <= ~hdrTog_r;
    end
  end

  // ---- Device domain: toggle synchronisers and chip-select sampling.
  logic [2:0] protoS_r;
  logic [2:0] hdrS_r;
  logic [1:0] csS_r;
  logic csPrev_r;
  logic [1:0] actS_r;

  // Two flops before use; the third stage only feeds edge detection.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      protoS_r <= 3'h0;
      hdrS_r <= 3'h0;
      csS_r <= 2'h3;
      csPrev_r <= 1'b1;
      actS_r <= 2'h0;
    end
    else
    begin
      protoS_r <= {protoS_r[1:0], protoTog_r};
      hdrS_r <= {hdrS_r[1:0], hdrTog_r};
      csS_r <= {csS_r[0], chipSelN};
      csPrev_r <= csS_r[1];
      actS_r <= {actS_r[0], xferActive};
    end
  end

  assign protoErrSync = protoS_r[2] ^ protoS_r[1];
  assign hdrErrSync = hdrS_r[2] ^ hdrS_r[1];
  // Release of chip select while a chunk is still in flight.
  assign framingSync = csS_r[1] && !csPrev_r && actS_r[1];

  // ---- Status flags.
  always_comb
  begin
    setEv = 8'h00;
    setEv[`BIT_RESET_DONE] = resetProcDone;
    setEv[`BIT_HDR_ERR] = hdrErrSync;
    setEv[`BIT_FRAMING_LOSS] = framingSync;
    setEv[`BIT_RX_OVF] = rxFrameDropped;
    setEv[`BIT_TX_UNF] = txUnderflow && txCutThrough_r;
    setEv[`BIT_TX_OVF] = txOverflow ||
                         (txChunkTaken && txCredit_r == 8'h00);
    setEv[`BIT_TX_PROTO] = protoErrSync;
    clrEv = wrStatus ? regWrData[7:0] : 8'h00;
    clrEv[`BIT_PHY_IRQ] = 1'b0;
  end

  // Sticky bits; a set in the clearing cycle wins.
  genvar g;
  generate
    for (g = 0; g < 7; g++)
    begin : gFlag
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          status_r[g] <= 1'(`RST_EVENT_STATUS >> g);
        else if (setEv[g])
          status_r[g] <= 1'b1;
        else if (clrEv[g])
          status_r[g] <= 1'b0;
      end
    end
  endgenerate

  // PHY interrupt mirrors the PHY's own request level.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status_r[`BIT_PHY_IRQ] <= 1'b0;
    else
      status_r[`BIT_PHY_IRQ] <= phyIrq;
  end

  // ---- Configuration: cut-through enable and payload size.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      payloadSize_r <= `RST_PAYLOAD_SIZE;
      txCutThrough_r <= 1'b0;
    end
    else if (wrConfig)
    begin
      if (regWrData[2:0] >= `PAYLOAD_8 && regWrData[2:0] <= `PAYLOAD_64)
        payloadSize_r <= regWrData[2:0];
      txCutThrough_r <= regWrData[`BIT_TX_CUT_THROUGH];
    end
  end

  mask_store uMask (
    .clk(clk),
    .rst(rst),
    .wrEn(wrMask),
    .wrData(regWrData[7:0]),
    .maskQ(maskQ)
  );

  // ---- Buffer counters; chunks counted in default-size units.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      txCredit_r <= `RST_TX_CREDIT;
    else if (txChunkTaken && !txChunkFreed && txCredit_r != 8'h00)
      txCredit_r <= txCredit_r - 8'h01;
    else if (txChunkFreed && !txChunkTaken &&
             txCredit_r != 8'(TxChunks))
      txCredit_r <= txCredit_r + 8'h01;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rxReady_r <= `RST_RX_READY;
    else if (rxChunkReady && !rxChunkRead && rxReady_r != 8'(TxChunks))
      rxReady_r <= rxReady_r + 8'h01;
    else if (rxChunkRead && !rxChunkReady && rxReady_r != 8'h00)
      rxReady_r <= rxReady_r - 8'h01;
  end

  // ---- Outputs: footer fields and interrupt, from flops.
  logic anyEvent;
  assign anyEvent = status_r[`BIT_RESET_DONE] ||
                    |(status_r & ~maskQ & 8'hBF);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      extendedStatusIndication <= 1'b1;
      interruptOutN <= 1'b0;
      footerTxCredit <= 5'(`RST_TX_CREDIT);
      footerRxReady <= 5'(`RST_RX_READY);
    end
    else
    begin
      extendedStatusIndication <= anyEvent;
      interruptOutN <= ~anyEvent;
      footerTxCredit <= txCredit_r[4:0];
      footerRxReady <= rxReady_r[4:0];
    end
  end

  assign chunkPayloadSize = payloadSize_r;

  // Read data registered one cycle after the read strobe.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      regRdData <= 32'h0000_0000;
    else if (regRd)
    begin
      if (hit(regAddr, `OFS_EVENT_STATUS))
        regRdData <= {22'h0, `TS_BITS_ZERO, status_r};
      else if (hit(regAddr, `OFS_BUFFER_STATUS))
        regRdData <= {16'h0, txCredit_r, rxReady_r};
      else if (hit(regAddr, `OFS_INT_MASK))
        regRdData <= {24'h0, maskQ};
      else if (hit(regAddr, `OFS_PROTOCOL_CONFIG))
        regRdData <= {22'h0, txCutThrough_r, 6'h0, payloadSize_r};
      else
        regRdData <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// >>> status_flags_sva.sv
// Port-level assertions for the status and buffer-credit block.
`default_nettype none
module status_flags_sva (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Events and register access.
  input wire logic phyIrq,
  input wire logic resetProcDone,
  input wire logic rxFrameDropped,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWrData,
  // Observed outputs.
  input wire logic [31:0] regRdData,
  input wire logic extendedStatusIndication,
  input wire logic interruptOutN,
  input wire logic [2:0] chunkPayloadSize
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Read data of the status word never shows the timestamp bits.
  a_ts_bits_zero: assert property (
    regRd && regAddr == 16'h0008 |=> regRdData[9:8] == 2'h0)
    else $error("timestamp bits not zero");
  a_buf_upper_zero: assert property (
    regRd && regAddr == 16'h000B |=> regRdData[31:16] == 16'h0)
    else $error("buffer status upper half not zero");
  // A PHY request held for three cycles must be seen by a read.
  a_phy_flag_seen: assert property (
    phyIrq [*3] ##0 (regRd && regAddr == 16'h0008) |=> regRdData[7])
    else $error("phy request not reported");
  // Reset-done ignores every mask, so its effect is fixed in time.
  a_reset_done_irq: assert property (
    resetProcDone |-> ##2 !interruptOutN)
    else $error("reset-done did not pull interrupt low");
  a_reset_done_extended_status_indication: assert property (
    resetProcDone |-> ##2 extendedStatusIndication)
    else $error("reset-done did not set footer status");
  a_rx_ovf_flag: assert property (
    rxFrameDropped ##1 !regWr ##1 (regRd && regAddr == 16'h0008)
    |=> regRdData[3])
    else $error("receive overflow not reported");
  a_size_taken: assert property (
    regWr && regAddr == 16'h0004 && regWrData[2:0] inside {[3'h3:3'h6]}
    |=> chunkPayloadSize == $past(regWrData[2:0]))
    else $error("payload size code not taken");
  a_size_refused: assert property (
    regWr && regAddr == 16'h0004 &&
    !(regWrData[2:0] inside {[3'h3:3'h6]}) |=> $stable(chunkPayloadSize))
    else $error("bad payload size code taken");
endmodule
bind spi_macphy_status_buffer_flags status_flags_sva chk (.clk(clk),
  .rst(rst), .phyIrq(phyIrq), .resetProcDone(resetProcDone),
  .rxFrameDropped(rxFrameDropped), .regWr(regWr), .regRd(regRd),
  .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .extendedStatusIndication(extendedStatusIndication),
  .interruptOutN(interruptOutN), .chunkPayloadSize(chunkPayloadSize));
`default_nettype wire

// >>> host_link_model.sv
// Host-side link model: gated link clock, chip select and headers.
`default_nettype none
module host_link_model (
  // Link clock and chip select, quiet between frames.
  output logic spiClk,
  output logic chipSelN,
  // Parsed header fields.
  output logic hdrValid,
  output logic hdrParityOk,
  output logic hdrIsData,
  output logic dataValid,
  output logic startValid,
  output logic endValid,
  output logic [3:0] startWordOfs,
  output logic [5:0] endByteOfs
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [14:0] f;
  // Fields are inverted outside the strobe so stale values are useless.
  assign {hdrParityOk, hdrIsData, dataValid, startValid, endValid,
    startWordOfs, endByteOfs} = hdrValid ? f : ~f;
  initial
  begin
    spiClk = 1'b0;
    chipSelN = 1'b1;
    hdrValid = 1'b0;
    f = 15'h0000;
  end
  // One frame: select, one header strobe, idle link cycles, release.
  task automatic frame(input logic [14:0] h);
    chipSelN = 1'b0;
    f = h;
    hdrValid = 1'b1;
    repeat (6)
    begin
      #83 spiClk = 1'b1;
      #77 spiClk = 1'b0;
      hdrValid = 1'b0;
    end
    chipSelN = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the status and buffer-credit block.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, spiClk, spiRst, chipSelN, hdrValid, hdrParityOk;
  logic hdrIsData, dataValid, startValid, endValid, xferActive, phyIrq;
  logic resetProcDone, rxFrameDropped, txUnderflow, txOverflow;
  logic txChunkTaken, txChunkFreed, rxChunkReady, rxChunkRead;
  logic regWr, regRd, extendedStatusIndication, interruptOutN;
  logic [3:0] startWordOfs;
  logic [5:0] endByteOfs;
  logic [15:0] regAddr;
  logic [31:0] regWrData, regRdData;
  logic [4:0] footerTxCredit, footerRxReady;
  logic [2:0] chunkPayloadSize;
  int errors, nCompared, cycles;
  spi_macphy_status_buffer_flags uut (.*);
  host_link_model link (.*);
  // Free-running device clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    nCompared++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk) #1;
    regWr = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge clk) #1;
    regWr = 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk) #1;
    regRd = 1'b1;
    regAddr = a;
    @(posedge clk) #1;
    regRd = 1'b0;
    check($sformatf("reg %h", a), regRdData, e);
  endtask
  task automatic pulse(ref logic s, input int n);
    repeat (n)
    begin
      @(posedge clk) #1;
      s = 1'b1;
      @(posedge clk) #1;
      s = 1'b0;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // The error reaches the status word a few cycles after the frame.
  task automatic fchk(input logic [14:0] h, input logic [31:0] e);
    link.frame(h);
    idle(10);
    rchk(16'h0008, e);
    wr(16'h0008, 32'h0000003F);
  endtask
  task automatic tallyAndFinish;
    if (errors == 0 && nCompared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, well above the length of the sequence below.
  initial
  begin
    cycles = 0;
    while (cycles < 20000)
    begin
      @(posedge clk);
      cycles++;
    end
    errors++;
    tallyAndFinish();
  end
  initial
  begin
    errors = 0;
    nCompared = 0;
    {rst, spiRst} = 2'h3;
    {xferActive, phyIrq, resetProcDone, rxFrameDropped, txUnderflow,
      txOverflow, txChunkTaken, txChunkFreed, rxChunkReady, rxChunkRead,
      regWr, regRd} = 12'h000;
    regAddr = 16'h0000;
    regWrData = 32'h00000000;
    idle(8);
    {rst, spiRst} = 2'h0;
    rchk(16'h0008, 32'h00000040);
    rchk(16'h000B, 32'h00003C00);
    rchk(16'h0001, 32'h00000000);
    check("irq", 32'(interruptOutN), 32'h0);
    check("extended_status_indication", 32'(extendedStatusIndication), 32'h1);
    check("fcred", 32'(footerTxCredit), 32'h1C);
    check("frdy", 32'(footerRxReady), 32'h0);
    wr(16'h000C, 32'h000000FF);
    rchk(16'h000C, 32'h000000FF);
    idle(3);
    check("irq", 32'(interruptOutN), 32'h0);
    wr(16'h0008, 32'h00000000);
    rchk(16'h0008, 32'h00000040);
    wr(16'h0008, 32'h00000040);
    rchk(16'h0008, 32'h00000000);
    idle(3);
    check("irq", 32'(interruptOutN), 32'h1);
    check("extended_status_indication", 32'(extendedStatusIndication), 32'h0);
    pulse(resetProcDone, 1);
    rchk(16'h0008, 32'h00000040);
    wr(16'h0008, 32'h00000040);
    phyIrq = 1'b1;
    idle(3);
    wr(16'h0008, 32'h00000080);
    rchk(16'h0008, 32'h00000080);
    check("irq", 32'(interruptOutN), 32'h1);
    phyIrq = 1'b0;
    idle(3);
    rchk(16'h0008, 32'h00000000);
    pulse(txUnderflow, 1);
    rchk(16'h0008, 32'h00000000);
    wr(16'h0004, 32'h00000206);
    rchk(16'h0004, 32'h00000206);
    pulse(txOverflow, 1);
    pulse(txUnderflow, 1);
    pulse(rxFrameDropped, 1);
    rchk(16'h0008, 32'h0000000E);
    wr(16'h000C, 32'h00000000);
    rchk(16'h000C, 32'h00000020);
    idle(3);
    check("irq", 32'(interruptOutN), 32'h0);
    check("extended_status_indication", 32'(extendedStatusIndication), 32'h1);
    wr(16'h0008, 32'h0000000E);
    // A new event in the clearing cycle must win over the clear.
    fork
      pulse(rxFrameDropped, 1);
      wr(16'h0008, 32'h00000008);
    join
    rchk(16'h0008, 32'h00000008);
    wr(16'h0008, 32'h00000008);
    idle(3);
    check("irq", 32'(interruptOutN), 32'h1);
    // Codes 3 to 6 are taken; 7 must leave the last code in place.
    for (int c = 3; c <= 7; c++)
    begin
      wr(16'h0004, 32'(c));
      idle(2);
      check("cps", 32'(chunkPayloadSize), c < 7 ? 32'(c) : 32'h6);
    end
    wr(16'h0004, 32'h00000003);
    fchk(15'h7C07, 32'h00000000);
    fchk(15'h7000, 32'h00000001);
    fchk(15'h7407, 32'h00000001);
    fchk(15'h7C87, 32'h00000001);
    fchk(15'h7C08, 32'h00000001);
    fchk(15'h7800, 32'h00000000);
    fchk(15'h7800, 32'h00000001);
    // Larger payload sizes; a non-data frame first lets the code settle.
    wr(16'h0004, 32'h00000004);
    fchk(15'h4000, 32'h00000000);
    fchk(15'h7C87, 32'h00000000);
    fchk(15'h7C10, 32'h00000001);
    wr(16'h0004, 32'h00000005);
    fchk(15'h4000, 32'h00000000);
    fchk(15'h7C1F, 32'h00000000);
    fchk(15'h7C20, 32'h00000001);
    fchk(15'h0000, 32'h00000020);
    xferActive = 1'b1;
    fchk(15'h4000, 32'h00000010);
    xferActive = 1'b0;
    pulse(txChunkTaken, 3);
    pulse(rxChunkReady, 2);
    idle(3);
    rchk(16'h000B, 32'h00003902);
    check("fcred", 32'(footerTxCredit), 32'h19);
    check("frdy", 32'(footerRxReady), 32'h02);
    pulse(txChunkTaken, 58);
    rchk(16'h0008, 32'h00000002);
    pulse(txChunkFreed, 1);
    pulse(rxChunkRead, 1);
    idle(3);
    rchk(16'h000B, 32'h00000101);
    tallyAndFinish();
  end
endmodule
`default_nettype wire
